// [spicfg_map.vh]
`ifndef SPICFG_MAP_VH
`define SPICFG_MAP_VH
`define SPICFG_OFS_TX_CHECK_VALUE   8'h18
`define SPICFG_OFS_CFG     8'h1C
`define SPICFG_OFS_CTRL    8'h28
`define SPICFG_RST_TX_CHECK_VALUE   16'h0000
`define SPICFG_RST_CFG     16'h0000
`define SPICFG_RST_POLY    16'h0007
`define SPICFG_CFG_MASK    16'h0FBF
`define SPICFG_B_CHW       0
`define SPICFG_B_SWL       1
`define SPICFG_B_SWH       2
`define SPICFG_B_IDLE      3
`define SPICFG_B_STDL      4
`define SPICFG_B_STDH      5
`define SPICFG_B_PCMS      7
`define SPICFG_B_ROLEL     8
`define SPICFG_B_ROLEH     9
`define SPICFG_B_AEN       10
`define SPICFG_B_PERS      11
`define SPICFG_B_C16       0
`define SPICFG_B_SPIEN     1
`define SPICFG_CK_BITS     4'h8
`endif

// [spicfg_crc.v]
`timescale 1ns/10ps
`include "spicfg_map.vh"
// Serial CRC engine, one data bit per enable, MSB first
module spicfg_crc (
  input  wire        clk,
  input  wire        rst_n,
  input  wire        clear,
  input  wire        bit_en,
  input  wire        bit_in,
  input  wire        wide,
  input  wire [15:0] poly,
  output reg  [15:0] crc_r
);
  reg [15:0] crc_nxt;
  reg        fb;
  always @* begin
    crc_nxt = crc_r;
    fb      = 1'b0;
    if (wide) begin
      fb      = crc_r[15] ^ bit_in;
      crc_nxt = {crc_r[14:0], 1'b0} ^ (fb ? poly : 16'h0000);
    end else begin
      fb      = crc_r[7] ^ bit_in;
      crc_nxt = {8'h00, crc_r[6:0], 1'b0} ^ (fb ? {8'h00, poly[7:0]} : 16'h0000);
    end
  end
  always @(posedge clk) begin
    if (!rst_n || clear)
      crc_r <= `SPICFG_RST_TX_CHECK_VALUE;
    else if (bit_en)
      crc_r <= crc_nxt;
  end
endmodule

// [spicfg_top.v]
`timescale 1ns/10ps
`include "spicfg_map.vh"
// Configuration and transmit CRC slice of the SPI/audio serial unit.
// Transmit bits are observed on the serial data output, sampled on the
// shifting clock edge that the link clock pin presents.
module spicfg_top (
  input  wire        MCLK,
  input  wire        RST_N,
  input  wire [7:0]  ADDR,
  input  wire [15:0] WDATA,
  input  wire        WR,
  input  wire        RD,
  output reg  [15:0] RDATA,
  input  wire        SCK_IN,
  input  wire        TXD_IN,
  input  wire        BUSY_IN,
  input  wire [15:0] CRC_POLY,
  output reg         PERSONALITY_AUDIO,
  output reg         AUDIO_ON,
  output reg         IDLE_CLOCK_LEVEL,
  output reg  [1:0]  AUDIO_STANDARD,
  output reg         PCM_LONG_SYNC,
  output reg  [1:0]  AUDIO_ROLE,
  output reg  [5:0]  CHANNEL_BITS,
  output reg  [5:0]  SAMPLE_BITS,
  output reg         UNIT_ACTIVE_FLAG
);
  reg [15:0] cfg_r;
  reg [1:0]  ctrl_r;
  reg [1:0]  sck_sync_r;
  reg [1:0]  txd_sync_r;
  reg [1:0]  bsy_sync_r;
  reg        sck_prev_r;
  reg [3:0]  bit_cnt_r;
  reg        crc_clear_r;
  wire [15:0] tx_check_value;
  wire        sck_edge;
  wire        crc_bit_en;
  wire        spi_mode;
  reg  [15:0] cfg_nxt;
  reg  [15:0] rd_nxt;

  function [5:0] spicfg_sample_bits;
    input [1:0] sel;
    begin
      case (sel)
        2'b00:   spicfg_sample_bits = 6'h10;
        2'b01:   spicfg_sample_bits = 6'h18;
        2'b10:   spicfg_sample_bits = 6'h20;
        default: spicfg_sample_bits = 6'h20;
      endcase
    end
  endfunction

  assign spi_mode = ~cfg_r[`SPICFG_B_PERS];
  // Shift edge: rising edge of the clock unless idle level is high
  assign sck_edge = (sck_sync_r[1] ^ sck_prev_r) & (sck_sync_r[1] ^ cfg_r[`SPICFG_B_IDLE]);
  assign crc_bit_en = sck_edge & spi_mode & ctrl_r[`SPICFG_B_SPIEN];

  spicfg_crc u_crc (
    .clk    (MCLK),
    .rst_n  (RST_N),
    .clear  (crc_clear_r),
    .bit_en (crc_bit_en),
    .bit_in (txd_sync_r[1]),
    .wide   (ctrl_r[`SPICFG_B_C16]),
    .poly   (CRC_POLY),
    .crc_r  (tx_check_value)
  );

  always @(posedge MCLK) begin
    if (!RST_N) begin
      sck_sync_r <= 2'b00;
      txd_sync_r <= 2'b00;
      bsy_sync_r <= 2'b00;
      sck_prev_r <= 1'b0;
    end else begin
      sck_sync_r <= {sck_sync_r[0], SCK_IN};
      txd_sync_r <= {txd_sync_r[0], TXD_IN};
      bsy_sync_r <= {bsy_sync_r[0], BUSY_IN};
      sck_prev_r <= sck_sync_r[1];
    end
  end

  always @* begin
    cfg_nxt = WDATA & `SPICFG_CFG_MASK;
    if (WDATA[`SPICFG_B_SWH:`SPICFG_B_SWL] != 2'b00)
      cfg_nxt[`SPICFG_B_CHW] = 1'b1;
  end

  always @(posedge MCLK) begin
    if (!RST_N) begin
      cfg_r       <= `SPICFG_RST_CFG;
      ctrl_r      <= 2'b00;
      crc_clear_r <= 1'b0;
    end else begin
      crc_clear_r <= 1'b0;
      if (WR && ADDR == `SPICFG_OFS_CFG)
        cfg_r <= cfg_nxt;
      if (WR && ADDR == `SPICFG_OFS_CTRL) begin
        ctrl_r <= WDATA[1:0];
        crc_clear_r <= WDATA[`SPICFG_B_SPIEN] & ~ctrl_r[`SPICFG_B_SPIEN];
      end
    end
  end

  // Frame bit counter gives software the frame boundary via busy
  always @(posedge MCLK) begin
    if (!RST_N || crc_clear_r)
      bit_cnt_r <= 4'h0;
    else if (crc_bit_en)
      bit_cnt_r <= (bit_cnt_r == (ctrl_r[`SPICFG_B_C16] ? 4'hF : 4'h7)) ? 4'h0 : bit_cnt_r + 4'h1;
  end

  always @* begin
    case (ADDR)
      `SPICFG_OFS_TX_CHECK_VALUE: rd_nxt = spi_mode ? tx_check_value : 16'h0000;
      `SPICFG_OFS_CFG:   rd_nxt = cfg_r;
      `SPICFG_OFS_CTRL:  rd_nxt = {14'h0000, ctrl_r};
      default:           rd_nxt = 16'h0000;
    endcase
  end

  always @(posedge MCLK) begin
    if (!RST_N) begin
      RDATA             <= 16'h0000;
      PERSONALITY_AUDIO <= 1'b0;
      AUDIO_ON          <= 1'b0;
      IDLE_CLOCK_LEVEL  <= 1'b0;
      AUDIO_STANDARD    <= 2'b00;
      PCM_LONG_SYNC     <= 1'b0;
      AUDIO_ROLE        <= 2'b00;
      CHANNEL_BITS      <= 6'h10;
      SAMPLE_BITS       <= 6'h10;
      UNIT_ACTIVE_FLAG  <= 1'b0;
    end else begin
      RDATA             <= RD ? rd_nxt : 16'h0000;
      PERSONALITY_AUDIO <= cfg_r[`SPICFG_B_PERS];
      AUDIO_ON          <= cfg_r[`SPICFG_B_PERS] & cfg_r[`SPICFG_B_AEN];
      IDLE_CLOCK_LEVEL  <= cfg_r[`SPICFG_B_IDLE];
      UNIT_ACTIVE_FLAG  <= bsy_sync_r[1] | (bit_cnt_r != 4'h0);
      if (spi_mode) begin
        AUDIO_STANDARD <= 2'b00;
        PCM_LONG_SYNC  <= 1'b0;
        AUDIO_ROLE     <= 2'b00;
        CHANNEL_BITS   <= 6'h10;
        SAMPLE_BITS    <= 6'h10;
      end else begin
        AUDIO_STANDARD <= cfg_r[`SPICFG_B_STDH:`SPICFG_B_STDL];
        PCM_LONG_SYNC  <= cfg_r[`SPICFG_B_PCMS] &
                          (cfg_r[`SPICFG_B_STDH:`SPICFG_B_STDL] == 2'b11);
        AUDIO_ROLE     <= cfg_r[`SPICFG_B_ROLEH:`SPICFG_B_ROLEL];
        CHANNEL_BITS   <= cfg_r[`SPICFG_B_CHW] ? 6'h20 : 6'h10;
        SAMPLE_BITS    <= spicfg_sample_bits(cfg_r[`SPICFG_B_SWH:`SPICFG_B_SWL]);
      end
    end
  end
endmodule

// [spicfg_top_assertions.sv]
`timescale 1ns/10ps
module spicfg_top_assertions (
  input logic        MCLK,
  input logic        RST_N,
  input logic [7:0]  ADDR,
  input logic [15:0] WDATA,
  input logic        WR,
  input logic        RD,
  input logic [15:0] RDATA,
  input logic        PERSONALITY_AUDIO,
  input logic        AUDIO_ON,
  input logic        IDLE_CLOCK_LEVEL,
  input logic [1:0]  AUDIO_STANDARD,
  input logic        PCM_LONG_SYNC,
  input logic [1:0]  AUDIO_ROLE,
  input logic [5:0]  CHANNEL_BITS,
  input logic [5:0]  SAMPLE_BITS
);
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RST_N);
  property p_force; SAMPLE_BITS != 6'h10 |-> CHANNEL_BITS == 6'h20; endproperty
  a_force: assert property (p_force) else $error("channel not forced");
  property p_samp; SAMPLE_BITS inside {6'h10, 6'h18, 6'h20}; endproperty
  a_samp: assert property (p_samp) else $error("sample width bad");
  property p_idle; WR && ADDR == 8'h1C |-> ##2 IDLE_CLOCK_LEVEL == $past(WDATA[3], 2); endproperty
  a_idle: assert property (p_idle) else $error("idle level bad");
  property p_pcm; PCM_LONG_SYNC |-> AUDIO_STANDARD == 2'h3; endproperty
  a_pcm: assert property (p_pcm) else $error("sync outside pcm");
  property p_on; AUDIO_ON |-> PERSONALITY_AUDIO; endproperty
  a_on: assert property (p_on) else $error("enable in spi");
  property p_pers; WR && ADDR == 8'h1C |-> ##2 PERSONALITY_AUDIO == $past(WDATA[11], 2); endproperty
  a_pers: assert property (p_pers) else $error("mode bad");
  property p_spi; !PERSONALITY_AUDIO |-> AUDIO_ROLE == 2'h0 && SAMPLE_BITS == 6'h10; endproperty
  a_spi: assert property (p_spi) else $error("spi fields leak");
  property p_rsv; $past(RD) && $past(ADDR) == 8'h1C |-> RDATA[15:12] == 4'h0 && !RDATA[6]; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved set");
endmodule
bind spicfg_top spicfg_top_assertions u_chk (.*);

// [spicfg_link_dev.sv]
`timescale 1ns/10ps
module spicfg_link_dev (
  output logic sck,
  output logic txd
);
  initial sck = 1'b0;
  initial txd = 1'b0;
  task automatic send(input logic [15:0] d, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      txd = d[i];
      #100 sck = 1'b1;
      #100 sck = 1'b0;
    end
    // Released line must not show a stale bit
    txd = ~txd;
  endtask
endmodule

// [spicfg_top_tb_top.sv]
`timescale 1ns/10ps
module spicfg_top_tb_top;
  logic        MCLK = 1'b0;
  logic        RST_N = 1'b0;
  logic [7:0]  ADDR = 8'h00;
  logic [15:0] WDATA = 16'h0000;
  logic        WR = 1'b0;
  logic        RD = 1'b0;
  logic        BUSY_IN = 1'b0;
  logic [15:0] CRC_POLY = 16'h0007;
  logic [15:0] RDATA, q;
  logic [1:0]  AUDIO_STANDARD, AUDIO_ROLE;
  logic [5:0]  CHANNEL_BITS, SAMPLE_BITS;
  logic        SCK_IN, TXD_IN, PERSONALITY_AUDIO, AUDIO_ON, IDLE_CLOCK_LEVEL, PCM_LONG_SYNC, UNIT_ACTIVE_FLAG;
  int          fails = 0;
  int          comparisons = 0;
  spicfg_top u_dut (.*);
  spicfg_link_dev u_dev (.sck(SCK_IN), .txd(TXD_IN));
  always #12.5 MCLK = ~MCLK;
  task automatic chk(input string n, input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", n, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge MCLK);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge MCLK);
    WR <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge MCLK);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge MCLK);
    RD <= 1'b0;
    @(negedge MCLK);
    q = RDATA;
  endtask
  function automatic logic [15:0] crc(input logic [15:0] d, input int n);
    logic [15:0] c;
    c = 16'h0000;
    for (int i = n - 1; i >= 0; i--)
      c = {c[14:0], 1'b0} ^ ((c[n-1] ^ d[i]) ? 16'h0007 : 16'h0000);
    return (n == 8) ? (c & 16'h00FF) : c;
  endfunction
  task automatic summarize;
    $display("Comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic t_cfg;
    logic [1:0]  i;
    logic [15:0] c;
    rd(8'h1C);
    chk("cfg reset", q, 16'h0000);
    for (int j = 0; j < 8; j++) begin
      i = j[1:0];
      c = 16'hF8C8 | {5'h0, j[2], i, 2'h0, i, 1'h0, i, j[2]};
      wr(8'h1C, 16'h0000);
      wr(8'h1C, c);
      rd(8'h1C);
      chk("cfg", q, (c & 16'h0FBF) | (i != 2'h0));
      chk("mode", {AUDIO_ON, PCM_LONG_SYNC, AUDIO_STANDARD, AUDIO_ROLE}, {j[2], i == 2'h3, i, i});
      chk("width", {CHANNEL_BITS, SAMPLE_BITS}, {(i == 2'h0 && !j[2]) ? 6'h10 : 6'h20, i == 2'h0 ? 6'h10 : i == 2'h1 ? 6'h18 : 6'h20});
    end
    wr(8'h1C, 16'h0000);
    wr(8'h1C, 16'h07BE);
    rd(8'h40);
    chk("spi", {q[10:0], IDLE_CLOCK_LEVEL, AUDIO_ON, PCM_LONG_SYNC, AUDIO_ROLE}, 16'h0010);
    chk("pers", {PERSONALITY_AUDIO, AUDIO_STANDARD, SAMPLE_BITS}, {1'b0, 2'b00, 6'h10});
  endtask
  task automatic t_crc(input logic [15:0] d, input int n);
    int k;
    BUSY_IN <= 1'b1;
    repeat (4) @(posedge MCLK);
    chk("busy", UNIT_ACTIVE_FLAG, 16'h0001);
    BUSY_IN <= 1'b0;
    wr(8'h1C, 16'h0000);
    wr(8'h28, 16'h0000);
    wr(8'h28, (n == 16) ? 16'h0003 : 16'h0002);
    u_dev.send(d, n);
    k = 0;
    while (UNIT_ACTIVE_FLAG !== 1'b0 && k < 100) begin
      @(posedge MCLK);
      k++;
    end
    if (k == 100) begin
      fails++;
      summarize;
    end
    repeat (4) @(posedge MCLK);
    rd(8'h18);
    chk("crc", q, crc(d, n));
    wr(8'h28, 16'h0000);
    wr(8'h1C, 16'h0800);
    rd(8'h18);
    chk("crc audio", q, 16'h0000);
  endtask
  initial begin
    repeat (5) @(posedge MCLK);
    RST_N <= 1'b1;
    t_cfg;
    t_crc(16'h00A5, 8);
    t_crc(16'hC3A5, 16);
    summarize;
  end
endmodule
